// >>> drpm_params.svh
// Constants of the DRAM power cap and meter register block
`ifndef DRPM_PARAMS_SVH
`define DRPM_PARAMS_SVH

// ************************************************************
// Register indices
// ************************************************************
`define DRPM_IDX_CAP 32'h0000_0618
`define DRPM_IDX_ENERGY 32'h0000_0619
`define DRPM_IDX_THROTTLE 32'h0000_061b
`define DRPM_IDX_INFO 32'h0000_061c

// ************************************************************
// Field layout
// ************************************************************
`define DRPM_CAP_LIMIT_HI 14
`define DRPM_CAP_LIMIT_LO 0
`define DRPM_CAP_EN_BIT 15
`define DRPM_CAP_WIN_EXP_HI 21
`define DRPM_CAP_WIN_EXP_LO 17
`define DRPM_CAP_WIN_FRAC_HI 23
`define DRPM_CAP_WIN_FRAC_LO 22
`define DRPM_CAP_LOCK_BIT 31
`define DRPM_CAP_WMASK 32'h80fe_ffff
`define DRPM_CAP_RESET 32'h0000_0000
`define DRPM_ZERO32 32'h0000_0000
`define DRPM_ZERO64 64'h0000_0000_0000_0000

// ************************************************************
// Timing
// ************************************************************
`define DRPM_CLK_PERIOD_PS 5000
`define DRPM_REFRESH_TIME_MS 1
`define DRPM_PS_PER_MS 1000000000
`define DRPM_REFRESH_CYCLES ((`DRPM_REFRESH_TIME_MS * `DRPM_PS_PER_MS) / `DRPM_CLK_PERIOD_PS)

`endif

// >>> drpm_pkg.sv
// Types shared by the DRAM power cap and meter block
package drpm_pkg;
  typedef enum logic [2:0] {
    DRPM_SEL_CAP,
    DRPM_SEL_ENERGY,
    DRPM_SEL_INFO,
    DRPM_SEL_THROTTLE,
    DRPM_SEL_NONE
  } drpm_sel_t;
endpackage

// >>> drpm_meter_if.sv
// Carrier of the running totals from the accumulator to the register file
`timescale 1ns/10ps
interface drpm_meter_if;
  logic [31:0] energy_total;
  logic [31:0] throttle_total;
  modport acc (output energy_total, output throttle_total);
  modport regs (input energy_total, input throttle_total);
endinterface

// >>> drpm_accum.sv
// Energy and throttled-time accumulators for the DRAM domain
`timescale 1ns/10ps
`include "drpm_params.svh"
module drpm_accum
  import drpm_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = `DRPM_REFRESH_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] energy_step,
  input wire logic time_tick,
  input wire logic below_requested,
  drpm_meter_if.acc meter
);
  logic [31:0] energy_run_reg, energy_run_next;
  logic [31:0] energy_pub_reg, energy_pub_next;
  logic [31:0] refresh_cnt_reg, refresh_cnt_next;
  logic [31:0] throttle_reg, throttle_next;
  logic refresh_due;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    refresh_due = (refresh_cnt_reg == 32'(REFRESH_CYCLES - 1));
    // Wraps silently; software handles the rollover
    energy_run_next = energy_run_reg + {16'h0000, energy_step};
    energy_pub_next = energy_pub_reg;
    refresh_cnt_next = refresh_cnt_reg + 32'h0000_0001;
    if (refresh_due)
    begin
      // Published value moves only on the refresh beat
      refresh_cnt_next = `DRPM_ZERO32;
      energy_pub_next = energy_run_next;
    end
    throttle_next = throttle_reg;
    if (time_tick && below_requested)
    begin
      throttle_next = throttle_reg + 32'h0000_0001;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      energy_run_reg <= `DRPM_ZERO32;
      energy_pub_reg <= `DRPM_ZERO32;
      refresh_cnt_reg <= `DRPM_ZERO32;
      throttle_reg <= `DRPM_ZERO32;
    end
    else
    begin
      energy_run_reg <= energy_run_next;
      energy_pub_reg <= energy_pub_next;
      refresh_cnt_reg <= refresh_cnt_next;
      throttle_reg <= throttle_next;
    end
  end

  assign meter.energy_total = energy_pub_reg;
  assign meter.throttle_total = throttle_reg;
endmodule // drpm_accum

// >>> drpm_regs.sv
// DRAM power cap and meter register bank, reached by indexed register access
// Notes on behaviour
// - The bank decodes its indices only when built for a server platform; otherwise every index is acknowledged with a fault.
// - Cap register bits 14:0 hold the average DRAM power ceiling in power units.
// - Cap bit 15 turns the ceiling on when one, off when zero.
// - Window bits 23:17 mean two to the Y times 1.F time units.
// - Once cap bit 31 is set, writes to the cap register are ignored until reset.
// - Energy register low 32 bits report total energy since cleared.
// - The energy value is refreshed about once each millisecond.
// - Info bits 14:0 report thermal specification power.
// - Info bits 30:16 report electrical minimum power.
// - Info bits 46:32 report electrical maximum power.
// - Info bits 53:48 report the largest allowed programmed time window.
// - Throttle register low 32 bits accumulate throttled time in time units.
// - Time counts only while running below the requested performance state.
`timescale 1ns/10ps
`include "drpm_params.svh"
module drpm_regs
  import drpm_pkg::*;
#(
  parameter bit SERVER_PLATFORM = 1'b1,
  parameter logic [14:0] THERMAL_POWER = 15'h0000,
  parameter logic [14:0] MIN_POWER = 15'h0000,
  parameter logic [14:0] MAX_POWER = 15'h0000,
  parameter logic [5:0] MAX_WINDOW = 6'h00,
  parameter int unsigned REFRESH_CYCLES = `DRPM_REFRESH_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_index,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  output logic reg_ack,
  output logic reg_fault,
  input wire logic [15:0] energy_step,
  input wire logic time_tick,
  input wire logic below_requested,
  output logic [14:0] cap_limit,
  output logic cap_enable,
  output logic [4:0] cap_win_exp,
  output logic [1:0] cap_win_frac,
  output logic cap_locked
);
  drpm_meter_if meter ();
  drpm_sel_t sel;
  logic [31:0] cap_reg, cap_next;
  logic [63:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic fault_reg, fault_next;
  logic [63:0] info_word;

  drpm_accum #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
  ) u_accum (
    .clk(clk),
    .rst(rst),
    .energy_step(energy_step),
    .time_tick(time_tick),
    .below_requested(below_requested),
    .meter(meter)
  );

  // ************************************************************
  // Index decode
  // ************************************************************
  always_comb
  begin
    if (!SERVER_PLATFORM)
    begin
      sel = DRPM_SEL_NONE;
    end
    else if (reg_index == `DRPM_IDX_CAP)
    begin
      sel = DRPM_SEL_CAP;
    end
    else if (reg_index == `DRPM_IDX_ENERGY)
    begin
      sel = DRPM_SEL_ENERGY;
    end
    else if (reg_index == `DRPM_IDX_INFO)
    begin
      sel = DRPM_SEL_INFO;
    end
    else if (reg_index == `DRPM_IDX_THROTTLE)
    begin
      sel = DRPM_SEL_THROTTLE;
    end
    else
    begin
      sel = DRPM_SEL_NONE;
    end
  end

  // Fixed ranges; gaps between fields stay zero
  assign info_word = {10'h000, MAX_WINDOW, 1'b0, MAX_POWER, 1'b0, MIN_POWER, 1'b0,
    THERMAL_POWER};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    cap_next = cap_reg;
    rdata_next = rdata_reg;
    ack_next = reg_rd || reg_wr;
    fault_next = (reg_rd || reg_wr) && (sel == DRPM_SEL_NONE);
    if (reg_wr && (sel == DRPM_SEL_CAP) && !cap_reg[`DRPM_CAP_LOCK_BIT])
    begin
      // Only defined fields store; upper word never exists
      cap_next = reg_wdata[31:0] & `DRPM_CAP_WMASK;
    end
    // Writes to the read-only indices fall through untouched
    if (reg_rd)
    begin
      case (sel)
        DRPM_SEL_CAP: rdata_next = {32'h0000_0000, cap_reg};
        DRPM_SEL_ENERGY: rdata_next = {32'h0000_0000, meter.energy_total};
        DRPM_SEL_INFO: rdata_next = info_word;
        DRPM_SEL_THROTTLE: rdata_next = {32'h0000_0000, meter.throttle_total};
        default: rdata_next = `DRPM_ZERO64;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cap_reg <= `DRPM_CAP_RESET;
      rdata_reg <= `DRPM_ZERO64;
      ack_reg <= 1'b0;
      fault_reg <= 1'b0;
    end
    else
    begin
      cap_reg <= cap_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      fault_reg <= fault_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_ack = ack_reg;
  assign reg_fault = fault_reg;
  assign cap_limit = cap_reg[`DRPM_CAP_LIMIT_HI:`DRPM_CAP_LIMIT_LO];
  assign cap_enable = cap_reg[`DRPM_CAP_EN_BIT];
  assign cap_win_exp = cap_reg[`DRPM_CAP_WIN_EXP_HI:`DRPM_CAP_WIN_EXP_LO];
  assign cap_win_frac = cap_reg[`DRPM_CAP_WIN_FRAC_HI:`DRPM_CAP_WIN_FRAC_LO];
  assign cap_locked = cap_reg[`DRPM_CAP_LOCK_BIT];
endmodule // drpm_regs

// >>> drpm_regs_checker.sv
// Concurrent checks on the DRAM power cap register bank ports
`timescale 1ns/10ps
`include "drpm_params.svh"
module drpm_regs_checker
#(
  parameter bit SERVER_PLATFORM = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_index,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_fault,
  input wire logic [14:0] cap_limit,
  input wire logic cap_enable,
  input wire logic [4:0] cap_win_exp,
  input wire logic [1:0] cap_win_frac,
  input wire logic cap_locked
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic req;
  logic mapped;
  logic info_sel;
  logic cap_wr;
  logic [23:0] cap_vec;
  logic [63:0] wd_q;
  assign req = reg_rd || reg_wr;
  assign info_sel = reg_index == `DRPM_IDX_INFO;
  assign mapped = SERVER_PLATFORM && (info_sel || reg_index == `DRPM_IDX_CAP
    || reg_index == `DRPM_IDX_ENERGY || reg_index == `DRPM_IDX_THROTTLE);
  assign cap_wr = reg_wr && mapped && reg_index == `DRPM_IDX_CAP;
  assign cap_vec = {cap_locked, cap_win_frac, cap_win_exp, cap_enable, cap_limit};
  // Write data of the previous edge, so field checks need no sliced past value
  always_ff @(posedge clk)
    wd_q <= reg_wdata;
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  ack_follows_a: assert property (reg_ack == $past(req))
    else $error("ack not a one-cycle answer to request");
  fault_unmap_a: assert property (req && !mapped |=> reg_fault)
    else $error("fault missing on unmapped index");
  fault_map_a: assert property (req && mapped |=> !reg_fault)
    else $error("fault on mapped index");
  cap_load_a: assert property (cap_wr && !cap_locked |=> cap_limit == wd_q[14:0]
    && cap_enable == wd_q[15]) else $error("cap limit or enable not loaded");
  win_load_a: assert property (cap_wr && !cap_locked |=> cap_win_exp == wd_q[21:17]
    && cap_win_frac == wd_q[23:22] && cap_locked == wd_q[31]) else $error("window not loaded");
  lock_hold_a: assert property (cap_locked |=> $stable(cap_vec))
    else $error("locked cap register changed");
  hi_zero_a: assert property (reg_rd && !info_sel |=> reg_rdata[63:32] == 32'h0000_0000)
    else $error("upper word not zero");
  info_resv_a: assert property (reg_rd && info_sel |=> reg_rdata[63:54] == 10'h000
    && !reg_rdata[47] && !reg_rdata[31] && !reg_rdata[15]) else $error("info reserved bit set");
  rdata_hold_a: assert property (!reg_rd [*2] |-> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule // drpm_regs_checker

bind drpm_regs drpm_regs_checker #(.SERVER_PLATFORM(SERVER_PLATFORM)) chk_u (.clk, .rst,
  .reg_rd, .reg_wr, .reg_index, .reg_wdata, .reg_rdata, .reg_ack, .reg_fault, .cap_limit,
  .cap_enable, .cap_win_exp, .cap_win_frac, .cap_locked);

// >>> drpm_regs_tb_top.sv
// Self-checking bench for the DRAM power cap register bank
`timescale 1ns/10ps
module drpm_regs_tb_top;
  typedef struct {logic w; logic [31:0] i; logic [63:0] d, e; logic f;} drpm_row_t;
  logic clk = 1'b0, rst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, reg_ack, reg_fault, nos_fault;
  logic time_tick = 1'b0, below_requested = 1'b0, cap_enable, cap_locked;
  logic [31:0] reg_index = 32'h0;
  logic [63:0] reg_wdata = 64'h0, reg_rdata, got, prev;
  logic [15:0] energy_step = 16'h0003;
  logic [14:0] cap_limit;
  logic [4:0] cap_win_exp;
  logic [1:0] cap_win_frac;
  int errors = 0, comparisons = 0;
  drpm_row_t rows [8] = '{'{1'b0, 32'h618, 64'h0, 64'h0, 1'b0},
    '{1'b1, 32'h618, 64'hffff_ffff_7fff_ffff, 64'h0, 1'b0},
    '{1'b0, 32'h618, 64'h0, 64'h00fe_ffff, 1'b0},
    '{1'b1, 32'h61c, 64'hffff_ffff_ffff_ffff, 64'h0, 1'b0},
    '{1'b1, 32'h61b, 64'hffff_ffff_ffff_ffff, 64'h0, 1'b0},
    '{1'b0, 32'h61c, 64'h0, 64'h002d_7abc_0567_1234, 1'b0},
    '{1'b0, 32'h61a, 64'h0, 64'h0, 1'b1}, '{1'b1, 32'h61d, 64'h0, 64'h0, 1'b1}};
  always #2.5 clk = ~clk;
  // Short refresh so the millisecond publish is seen within a few cycles
  drpm_regs #(.THERMAL_POWER(15'h1234), .MIN_POWER(15'h0567), .MAX_POWER(15'h7abc),
    .MAX_WINDOW(6'h2d), .REFRESH_CYCLES(8)) dut_u (.clk, .rst, .reg_rd, .reg_wr, .reg_index,
    .reg_wdata, .reg_rdata, .reg_ack, .reg_fault, .energy_step, .time_tick, .below_requested,
    .cap_limit, .cap_enable, .cap_win_exp, .cap_win_frac, .cap_locked);
  drpm_regs #(.SERVER_PLATFORM(1'b0)) nos_u (.clk, .rst, .reg_rd, .reg_wr, .reg_index,
    .reg_wdata, .reg_rdata(), .reg_ack(), .reg_fault(nos_fault), .energy_step, .time_tick,
    .below_requested, .cap_limit(), .cap_enable(), .cap_win_exp(), .cap_win_frac(),
    .cap_locked());
  task automatic chk_w(input logic [63:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, e);
    chk_w({63'h0, g}, {63'h0, e});
  endtask
  // Entered just after a rising edge; one request, answer checked mid-cycle
  task automatic acc(input logic w, input logic [31:0] i, input logic [63:0] d, input logic f);
    reg_wr <= w;
    reg_rd <= !w;
    reg_index <= i;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    got = reg_rdata;
    chk_b(reg_ack, 1'b1);
    chk_b(reg_fault, f);
    chk_b(nos_fault, 1'b1);
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    chk_w({reg_ack, reg_fault, cap_locked, cap_enable, cap_win_frac, cap_win_exp}, 64'h0);
    chk_w(reg_rdata, 64'h0);
    rst <= 1'b0;
    $display("test reset done");
    foreach (rows[k])
    begin
      acc(rows[k].w, rows[k].i, rows[k].d, rows[k].f);
      if (!rows[k].w)
        chk_w(got, rows[k].e);
    end
    chk_w({cap_locked, cap_win_frac, cap_win_exp}, 64'h7f);
    $display("test rows done");
    acc(1'b1, 32'h618, 64'h8000_8123, 1'b0);
    chk_w({cap_locked, cap_enable, cap_limit}, {1'b1, 1'b1, 15'h0123});
    acc(1'b1, 32'h618, 64'h0, 1'b0);
    acc(1'b0, 32'h618, 64'h0, 1'b0);
    chk_w(got, 64'h8000_8123);
    $display("test lock done");
    acc(1'b0, 32'h619, 64'h0, 1'b0);
    prev = got;
    repeat (6) @(posedge clk);
    acc(1'b0, 32'h619, 64'h0, 1'b0);
    chk_w(got - prev, 64'h18);
    chk_w(prev % 64'h18, 64'h0);
    $display("test energy done");
    // Ticks while not held back must not count
    time_tick <= 1'b1;
    repeat (3) @(posedge clk);
    below_requested <= 1'b1;
    repeat (5) @(posedge clk);
    time_tick <= 1'b0;
    repeat (3) @(posedge clk);
    below_requested <= 1'b0;
    acc(1'b0, 32'h61b, 64'h0, 1'b0);
    chk_w(got, 64'h5);
    $display("test throttle done");
    rst <= 1'b1;
    // Full-width step after this reset, so the upper step bits get exercised
    energy_step <= 16'hffff;
    @(posedge clk);
    rst <= 1'b0;
    chk_b(cap_locked, 1'b0);
    acc(1'b0, 32'h619, 64'h0, 1'b0);
    chk_w(got, 64'h0);
    acc(1'b1, 32'h618, 64'h1, 1'b0);
    acc(1'b0, 32'h618, 64'h0, 1'b0);
    chk_w(got, 64'h1);
    // First publish lands on the eighth edge after release
    repeat (2) @(posedge clk);
    acc(1'b0, 32'h619, 64'h0, 1'b0);
    chk_w(got, 64'h0007_fff8);
    $display("test second reset done");
    print_verdict();
  end
endmodule // drpm_regs_tb_top
